/* charger_mask_map.svh */
// register offsets, field positions and reset values of the two charger mask registers
// assumes an i2c register front end that presents byte-wide reads and writes by offset
`ifndef CHARGER_MASK_MAP_SVH
`define CHARGER_MASK_MAP_SVH

`define MASK_A_OFFSET 8'h29
`define MASK_B_OFFSET 8'h2a
`define MASK_A_RESET 8'h00
`define MASK_B_RESET 8'h00
// writable bits; the rest are reserved and read as zero
`define MASK_A_WMASK 8'hd7
`define MASK_B_WMASK 8'h7f

`define A_CHG_BIT 7
`define A_ICO_BIT 6
`define A_VBUS_BIT 4
`define A_DIE_THERMAL_REGULATION_BIT 2
`define A_VBAT_BIT 1
`define A_BC_BIT 0
`define B_DPDM_BIT 6
`define B_ADC_BIT 5
`define B_VSYS_BIT 4
`define B_FAST_BIT 3
`define B_TRICKLE_BIT 2
`define B_PRE_BIT 1
`define B_TOPOFF_BIT 0

`define EVENT_COUNT 13

`endif

/* charger_mask_pkg.sv */
// types shared by the charger interrupt mask block
// assumes charger_mask_map.svh is compiled alongside
package charger_mask_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // one-cycle event pulses from the charger core, in mask bit order
  typedef struct packed {
    logic charge_status;
    logic input_current_optimiser;
    logic input_bus_status;
    logic die_thermal_regulation;
    logic battery_present;
    logic usb_charger_detect;
    logic data_line_detect_done;
    logic adc_done;
    logic minimum_system_voltage_regulation;
    logic fast_charge_timer;
    logic trickle_timer;
    logic precharge_timer;
    logic topoff_timer;
  } charger_events_t;

endpackage

/* charger_interrupt_mask_regs.sv */
// two charger event mask registers and the masked interrupt pulse they steer
// assumes events arrive as one-cycle pulses on mclk from the charger core, and an
// i2c slave front end on mclk hands over decoded register reads and writes
//
// Operation
// - mask a bit 7 set stops charge status changes from pulsing the interrupt.
// - mask a bit 6 set stops input current optimiser status changes from pulsing it.
// - mask a bit 4 set stops input bus status changes from pulsing it.
// - mask a bit 2 set stops entry into die thermal regulation from pulsing it.
// - mask a bit 1 set stops battery presence changes from pulsing it.
// - mask a bit 0 set stops usb charger detection status changes from pulsing it.
// - mask b bit 6 set stops data line detection completion from pulsing it.
// - mask b bit 5 set stops adc completion pulses, which exist only in one-shot mode.
// - mask b bit 4 set stops both entry to and exit from minimum system regulation.
// - mask b bit 3 set stops fast charge timer expiry from pulsing it.
// - mask b bit 2 set stops trickle timer expiry from pulsing it.
// - mask b bit 1 set stops precharge timer expiry from pulsing it.
// - mask b bit 0 set stops topoff timer expiry from pulsing it.
// - mask a sits at offset 29h and resets to zero.
// - mask b sits at offset 2ah and resets to zero.
`include "charger_mask_map.svh"

module charger_interrupt_mask_regs
(
  input wire logic mclk,
  input wire logic rst,
  input wire charger_mask_pkg::reg_req_t req,
  input wire logic reg_reset_cmd,
  input wire logic adc_one_shot,
  input wire charger_mask_pkg::charger_events_t events,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic irq_pulse,
  output logic [7:0] charger_event_mask_a,
  output logic [7:0] charger_event_mask_b
);

  logic [7:0] mask_a_q;
  logic [7:0] mask_a_d;
  logic [7:0] mask_b_q;
  logic [7:0] mask_b_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic irq_q;
  logic irq_d;
  logic [`EVENT_COUNT-1:0] ev_vec;
  logic [`EVENT_COUNT-1:0] en_vec;

  // register file
  always_comb
  begin
    mask_a_d = mask_a_q;
    mask_b_d = mask_b_q;
    if (reg_reset_cmd)
    begin
      mask_a_d = `MASK_A_RESET;
      mask_b_d = `MASK_B_RESET;
    end
    else if (req.wr)
    begin
      if (req.addr == `MASK_A_OFFSET)
      begin
        mask_a_d = req.wdata & `MASK_A_WMASK;
      end
      if (req.addr == `MASK_B_OFFSET)
      begin
        mask_b_d = req.wdata & `MASK_B_WMASK;
      end
    end
  end

  // read port: unmapped offsets answer zero
  always_comb
  begin
    rvalid_d = req.rd;
    rdata_d = 8'h00;
    if (req.rd)
    begin
      case (req.addr)
        `MASK_A_OFFSET: rdata_d = mask_a_q & `MASK_A_WMASK;
        `MASK_B_OFFSET: rdata_d = mask_b_q & `MASK_B_WMASK;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // event to mask pairing, one entry per event
  always_comb
  begin
    ev_vec = events;
    en_vec = {~mask_a_q[`A_CHG_BIT],
      ~mask_a_q[`A_ICO_BIT],
      ~mask_a_q[`A_VBUS_BIT],
      ~mask_a_q[`A_DIE_THERMAL_REGULATION_BIT],
      ~mask_a_q[`A_VBAT_BIT],
      ~mask_a_q[`A_BC_BIT],
      ~mask_b_q[`B_DPDM_BIT],
      // adc completion only interrupts in one-shot mode
      ~mask_b_q[`B_ADC_BIT] & adc_one_shot,
      ~mask_b_q[`B_VSYS_BIT],
      ~mask_b_q[`B_FAST_BIT],
      ~mask_b_q[`B_TRICKLE_BIT],
      ~mask_b_q[`B_PRE_BIT],
      ~mask_b_q[`B_TOPOFF_BIT]};
    // masks act on the current register value, so a write takes effect next cycle
    irq_d = |(ev_vec & en_vec);
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      mask_a_q <= `MASK_A_RESET;
      mask_b_q <= `MASK_B_RESET;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      mask_a_q <= mask_a_d;
      mask_b_q <= mask_b_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      irq_q <= irq_d;
    end
  end

  assign rdata = rdata_q;
  assign rvalid = rvalid_q;
  assign irq_pulse = irq_q;
  assign charger_event_mask_a = mask_a_q;
  assign charger_event_mask_b = mask_b_q;

endmodule // charger_interrupt_mask_regs

/* mask_monitor.sv */
// port assertions for the charger mask block
// assumes it is bound onto charger_interrupt_mask_regs
module mask_monitor
(
  input wire logic mclk,
  input wire logic rst,
  input wire charger_mask_pkg::reg_req_t req,
  input wire logic reg_reset_cmd,
  input wire logic adc_one_shot,
  input wire charger_mask_pkg::charger_events_t events,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic irq_pulse,
  input wire logic [7:0] charger_event_mask_a,
  input wire logic [7:0] charger_event_mask_b
);
  wire [7:0] ma = charger_event_mask_a;
  wire [7:0] mb = charger_event_mask_b;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  rd_ans_a: assert property (req.rd |=> rvalid) else $error("no rvalid");
  rd_a_a: assert property (req.rd && req.addr == 8'h29 |=> rdata == $past(ma)) else $error("rd a");
  rd_b_a: assert property (req.rd && req.addr == 8'h2a |=> rdata == $past(mb)) else $error("rd b");
  resv_a_a: assert property ((ma & 8'h28) == 8'h00) else $error("resv a");
  resv_b_a: assert property (!mb[7]) else $error("resv b");
  wr_a_a: assert property (req.wr && req.addr == 8'h29 && !reg_reset_cmd
    |=> ma == ($past(req.wdata) & 8'hd7)) else $error("wr a");
  cmd_clr_a: assert property (reg_reset_cmd |=> (ma | mb) == 8'h00) else $error("cmd");
  chg_irq_a: assert property (events.charge_status && !ma[7] |=> irq_pulse) else $error("irq");
  adc_gate_a: assert property (events == 13'h0020 && !adc_one_shot |=> !irq_pulse)
    else $error("adc gate");
endmodule // mask_monitor

bind charger_interrupt_mask_regs mask_monitor mon_u (.mclk(mclk), .rst(rst), .req(req),
  .reg_reset_cmd(reg_reset_cmd), .adc_one_shot(adc_one_shot), .events(events),
  .rdata(rdata), .rvalid(rvalid),
  .irq_pulse(irq_pulse), .charger_event_mask_a(charger_event_mask_a),
  .charger_event_mask_b(charger_event_mask_b));

/* host_port.sv */
// host model issuing decoded register requests on the falling edge
// assumes reads are answered one clock later
module host_port
(
  input wire logic mclk,
  output charger_mask_pkg::reg_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // a missing answer reads back as unknown so it cannot pass a compare
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] wd,
    output logic [7:0] d);
    @(negedge mclk) req = '{w, !w, a, wd};
    @(negedge mclk) req = '0;
    d = rvalid ? rdata : 8'hxx;
  endtask
endmodule // host_port

/* charger_interrupt_mask_regs_tb.sv */
// self-checking bench for the charger mask block
// assumes host_port as register master and mask_monitor bound in
module charger_interrupt_mask_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst = 1, cmd = 0, rv, irq;
  logic [7:0] rd, d, ma, mb;
  logic one_shot = 1;
  charger_mask_pkg::reg_req_t req;
  charger_mask_pkg::charger_events_t ev = '0;
  int failures = 0, checked = 0;
  byte pos[13] = '{15, 14, 12, 10, 9, 8, 6, 5, 4, 3, 2, 1, 0};
  always #10 mclk = ~mclk;
  host_port host_u (.mclk(mclk), .req(req), .rdata(rd), .rvalid(rv));
  charger_interrupt_mask_regs dut_u (.mclk(mclk), .rst(rst), .req(req), .reg_reset_cmd(cmd),
    .adc_one_shot(one_shot), .events(ev), .rdata(rd), .rvalid(rv), .irq_pulse(irq),
    .charger_event_mask_a(ma), .charger_event_mask_b(mb));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e)
    begin
      failures++;
      $display("[FAIL] %0t saw %h want %h", $time, s, e);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] x);
    host_u.xfer(1'b1, a, x, d);
  endtask
  task automatic r(input logic [7:0] a, input logic [7:0] e);
    host_u.xfer(1'b0, a, 8'h00, d);
    chk(d, e);
  endtask
  // mask {a,b} is written first so the event sees the settled mask
  task automatic pm(input logic [15:0] k, input logic [12:0] e, input logic x);
    w(8'h29, k[15:8]);
    w(8'h2a, k[7:0]);
    @(negedge mclk) ev = e;
    @(negedge mclk) ev = '0;
    chk({7'h00, irq}, {7'h00, x});
  endtask
  task automatic wrap_up;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(negedge mclk);
    rst = 0;
    r(8'h29, 8'h00);
    r(8'h2a, 8'h00);
    w(8'h29, 8'hff);
    w(8'h2a, 8'hff);
    chk(ma, 8'hd7);
    chk(mb, 8'h7f);
    r(8'h29, 8'hd7);
    r(8'h2a, 8'h7f);
    r(8'h2b, 8'h00);
    $display("registers done");
    for (int i = 0; i < 13; i++)
    begin
      pm(16'h0001 << pos[i], 13'h1000 >> i, 1'b0);
      pm(~(16'h0001 << pos[i]), 13'h1000 >> i, 1'b1);
    end
    // adc completion outside one-shot mode never interrupts, even unmasked
    one_shot = 0;
    pm(16'h0000, 13'h0020, 1'b0);
    one_shot = 1;
    $display("event masks done");
    @(negedge mclk) cmd = 1;
    @(negedge mclk) cmd = 0;
    r(8'h29, 8'h00);
    r(8'h2a, 8'h00);
    chk(ma, 8'h00);
    chk(mb, 8'h00);
    $display("reset command done");
    w(8'h29, 8'hff);
    w(8'h2a, 8'hff);
    @(negedge mclk) rst = 1;
    @(negedge mclk) rst = 0;
    r(8'h29, 8'h00);
    r(8'h2a, 8'h00);
    $display("mid-run reset done");
    wrap_up();
  end
endmodule // charger_interrupt_mask_regs_tb
